// ==== pssq_pkg.sv ====
// How it works
// - six power states in one machine
// - rest request on live link sends sleep
// - received sleep command opens acknowledge window
// - reject during acknowledge returns to normal
// - window expiry sends sleep as acknowledgement
// - sent and received sleep enters quiet
// - handshake timeout fails back to active
// - partner abort ends in handshake timeout
// - entering normal clears seen and reject
// - quiet sends silence, energy detect off
// - sleep entered once line activity stops
// - sleep powers transmitter down, awaits wake
// - wake on live link sends wake command
// - wake on dead link sends wake pulse
// - receiver not ready: link first, then command
// - detected wake forwarded to other ports
// - forwarding leaves the cycle after detection
// - wake indication on link-down wake events
// - energy detection done well within 2 ms
// - early wake cancels sleep entry
// - late wake latched, acted on in sleep
// - sleep command lasts 64 bit times
// - wake command lasts 64 bit times
// - wake pulse lasts about one millisecond
// - acknowledge window about eight milliseconds
package pssq_pkg;

    // --------
    // timing
    // --------
    localparam int CLK_MHZ          = 40;
    localparam int CLK_PERIOD_NS    = 25;
    localparam int BIT_TIME_NS      = 10;      // 100 Mbit/s line rate
    localparam int CMD_MIN_BITS     = 64;
    localparam int CMD_CYCLES       =
        (CMD_MIN_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_PULSE_US    = 1000;
    localparam int PULSE_CYC_DEF    = WAKE_PULSE_US * CLK_MHZ;
    localparam int ACK_WINDOW_US    = 8000;
    localparam int ACK_CYC_DEF      = ACK_WINDOW_US * CLK_MHZ;
    localparam int HS_TIMEOUT_US    = 16000;
    localparam int HS_CYC_DEF       = HS_TIMEOUT_US * CLK_MHZ;
    localparam int ENERGY_FILTER_NS = 1000;    // far below the 2 ms limit
    localparam int ENERGY_CYCLES    =
        (ENERGY_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W            = 20;
    localparam int CNT_W            = 6;

    // --------
    // register map
    // --------
    localparam int ADDR_W           = 8;
    localparam int DATA_W           = 32;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CMD    = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int CTRL_CAP_BIT     = 0;
    localparam int CTRL_FWD_BIT     = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int CMD_REST_BIT     = 0;
    localparam int CMD_WAKE_BIT     = 1;
    localparam int CMD_REJECT_BIT   = 2;
    localparam int STAT_STATE_LSB   = 0;
    localparam int STAT_PEND_BIT    = 8;
    localparam int STAT_LPS_BIT     = 9;
    localparam int STAT_FAIL_BIT    = 16;
    localparam int STAT_WEVT_BIT    = 17;

    // --------
    // types
    // --------
    typedef enum logic [1:0] {
        MODE_SILENT   = 2'h0,
        MODE_TRAINING = 2'h1,
        MODE_NORMAL   = 2'h2
    } pssq_txmode_t;

    typedef enum logic [5:0] {
        ST_NORMAL = 6'h01,
        ST_ACKWT  = 6'h02,
        ST_HSREQ  = 6'h04,
        ST_QUIET  = 6'h08,
        ST_FAILED = 6'h10,
        ST_SLEEP  = 6'h20
    } pssq_state_t;

    typedef struct packed {
        logic txLps;
        logic txWur;
        logic txPulse;
        logic txSilent;
        logic txPowerDown;
        logic energyDetEn;
    } pssq_txctl_t;

    localparam pssq_txctl_t TXCTL_RST = 6'h01;

endpackage

// ==== pssq_sequencer.sv ====
`timescale 1ns/1ps
module pssq_sequencer
    import pssq_pkg::*;
#(
    parameter logic [TMR_W-1:0] ACK_WIN_CYC = TMR_W'(ACK_CYC_DEF),
    parameter logic [TMR_W-1:0] HS_TO_CYC   = TMR_W'(HS_CYC_DEF),
    parameter logic [TMR_W-1:0] PULSE_CYC   = TMR_W'(PULSE_CYC_DEF)
) (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    // register port
    input  wire logic [ADDR_W-1:0]  regAddr,
    input  wire logic [DATA_W-1:0]  regWrData,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output      logic [DATA_W-1:0]  regRdData,
    // coding sublayer status, same clock
    input  wire pssq_txmode_t       txMode,
    input  wire logic               rcvrOk,
    input  wire logic               lpsRcvd,
    input  wire logic               wurRcvd,
    input  wire logic               lineActive,
    input  wire logic               idleSlot,
    // asynchronous pins
    input  wire logic               lineEnergyPin,
    input  wire logic               wakeFwdInPin,
    // transmitter control and indications
    output      pssq_txctl_t        txCtl,
    output      pssq_state_t        seqState,
    output      logic               wakeIndicate,
    output      logic               sleepFailInd,
    output      logic               wakeFwdOut
);

    // --------
    // constants derived from parameters
    // --------
    localparam logic [TMR_W-1:0] ACK_LAST   = ACK_WIN_CYC - TMR_W'(1);
    localparam logic [TMR_W-1:0] HS_LAST    = HS_TO_CYC - TMR_W'(1);
    localparam logic [TMR_W-1:0] PULSE_LAST = PULSE_CYC - TMR_W'(1);
    localparam logic [TMR_W-1:0] WUR_LAST   = TMR_W'(CMD_CYCLES - 1);
    localparam logic [CNT_W-1:0] LPS_DONE   = CNT_W'(CMD_CYCLES);
    localparam logic [CNT_W-1:0] NRG_LAST   = CNT_W'(ENERGY_CYCLES - 1);
    localparam logic [CNT_W-1:0] NRG_FULL   = CNT_W'(ENERGY_CYCLES);

    // --------
    // state declarations
    // --------
    logic [1:0]        ctrl_reg,     ctrl_next;
    logic [DATA_W-1:0] rdData_reg,   rdData_next;
    pssq_state_t       state_reg,    state_next;
    logic [TMR_W-1:0]  tmr_reg,      tmr_next;
    logic [CNT_W-1:0]  lpsCnt_reg,   lpsCnt_next;
    logic [TMR_W-1:0]  wakeCnt_reg,  wakeCnt_next;
    logic [CNT_W-1:0]  nrgCnt_reg,   nrgCnt_next;
    logic              restPend_reg, restPend_next;
    logic              lpsSeen_reg,  lpsSeen_next;
    logic              reject_reg,   reject_next;
    logic              wakePend_reg, wakePend_next;
    logic              wakeHold_reg, wakeHold_next;
    logic              fail_reg,     fail_next;
    logic              wakeEvt_reg,  wakeEvt_next;
    pssq_txctl_t       txCtl_reg,    txCtl_next;
    logic              wInd_reg,     wInd_next;
    logic              sFail_reg,    sFail_next;
    logic              fwd_reg,      fwd_next;
    logic              nrgSyncA_reg;
    logic              nrgSyncB_reg;
    logic              fwdSyncA_reg;
    logic              fwdSyncB_reg;
    logic              fwdSyncC_reg;

    // bus decode and events
    logic swRest;
    logic swWake;
    logic swReject;
    logic stWrite;
    logic fwdIn;
    logic energyHit;
    logic wakeReq;
    logic anyWake;
    logic linkDown;
    logic lpsDone;
    logic wakeDone;

    // --------
    // event decode
    // --------
    // write strobes to the command word act as one-cycle pulses
    assign swRest    = regWr && regAddr == REG_CMD && regWrData[CMD_REST_BIT];
    assign swWake    = regWr && regAddr == REG_CMD && regWrData[CMD_WAKE_BIT];
    assign swReject  = regWr && regAddr == REG_CMD
                       && regWrData[CMD_REJECT_BIT];
    assign stWrite   = regWr && regAddr == REG_STATUS;
    // forwarded wake from another port: rising edge, read after sync
    assign fwdIn     = fwdSyncB_reg && !fwdSyncC_reg;
    // energy counts only while detection is enabled
    assign energyHit = nrgSyncB_reg && txCtl_reg.energyDetEn
                       && nrgCnt_reg == NRG_LAST;
    assign wakeReq   = swWake || fwdIn;
    assign anyWake   = wakeReq || wurRcvd || energyHit;
    assign linkDown  = txMode != MODE_NORMAL;
    assign lpsDone   = lpsCnt_reg == LPS_DONE;
    assign wakeDone  = (txCtl_reg.txWur && wakeCnt_reg == WUR_LAST)
                       || (txCtl_reg.txPulse
                           && wakeCnt_reg == PULSE_LAST);

    // --------
    // register port
    // --------
    // read data stands only in the cycle after the read strobe
    always_comb begin
        ctrl_next   = ctrl_reg;
        rdData_next = '0;
        if (regWr && regAddr == REG_CTRL) begin
            ctrl_next = regWrData[1:0];
        end
        if (regRd) begin
            case (regAddr)
                REG_CTRL: begin
                    rdData_next[1:0] = ctrl_reg;
                end
                REG_STATUS: begin
                    rdData_next[STAT_STATE_LSB +: 6] = state_reg;
                    rdData_next[STAT_PEND_BIT]       = wakePend_reg;
                    rdData_next[STAT_LPS_BIT]        = lpsSeen_reg;
                    rdData_next[STAT_FAIL_BIT]       = fail_reg;
                    rdData_next[STAT_WEVT_BIT]       = wakeEvt_reg;
                end
                default: begin
                    rdData_next = '0;   // command word and holes read zero
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_reg   <= CTRL_RST;
            rdData_reg <= '0;
        end else begin
            ctrl_reg   <= ctrl_next;
            rdData_reg <= rdData_next;
        end
    end

    // --------
    // power state machine
    // --------
    // one comb block for the machine and its latches; timers are in the next block
    always_comb begin
        state_next    = state_reg;
        restPend_next = restPend_reg;
        lpsSeen_next  = lpsSeen_reg;
        reject_next   = reject_reg;
        wakePend_next = wakePend_reg;
        wakeHold_next = wakeHold_reg;
        fail_next     = fail_reg;
        wakeEvt_next  = wakeEvt_reg;

        // transitions
        case (state_reg)
            ST_NORMAL: begin
                if (ctrl_reg[CTRL_CAP_BIT] && txMode == MODE_NORMAL
                    && !wakePend_reg && !wakeReq) begin
                    if (restPend_reg) begin
                        state_next = ST_HSREQ;
                    end else if (lpsSeen_reg) begin
                        state_next = ST_ACKWT;
                    end
                end
            end
            ST_ACKWT: begin
                if (reject_reg || anyWake || wakePend_reg) begin
                    state_next = ST_NORMAL;
                end else if (tmr_reg == ACK_LAST) begin
                    state_next = ST_HSREQ;
                end
            end
            ST_HSREQ: begin
                if (anyWake || wakePend_reg) begin
                    state_next = ST_NORMAL;
                end else if (lpsDone && lpsSeen_reg) begin
                    state_next = ST_QUIET;
                end else if (tmr_reg == HS_LAST) begin
                    // partner abort shows up only as this timeout
                    state_next = ST_FAILED;
                end
            end
            ST_QUIET: begin
                if (!lineActive) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_FAILED: begin
                state_next = ST_NORMAL;
            end
            ST_SLEEP: begin
                if (wakePend_reg || wakeHold_reg || anyWake) begin
                    state_next = ST_NORMAL;
                end
            end
            default: begin
                state_next = ST_NORMAL;
            end
        endcase

        // rest request pending until normal moves to the handshake
        if (state_next == ST_HSREQ && state_reg == ST_NORMAL) begin
            restPend_next = 1'b0;
        end
        if (swRest) begin
            restPend_next = 1'b1;
        end

        // seen and reject clear on entry to normal; a new set wins
        if (state_next == ST_NORMAL && state_reg != ST_NORMAL) begin
            lpsSeen_next = 1'b0;
            reject_next  = 1'b0;
        end
        if (state_reg == ST_NORMAL) begin
            reject_next = 1'b0;
        end
        if (lpsRcvd) begin
            lpsSeen_next = 1'b1;
        end
        if (swReject && state_reg == ST_ACKWT) begin
            reject_next = 1'b1;
        end

        // late wake in quiet cannot stop the descent, so hold it
        if (state_reg == ST_SLEEP) begin
            wakeHold_next = 1'b0;
        end
        if (state_reg == ST_QUIET && anyWake) begin
            wakeHold_next = 1'b1;
        end

        // local wake stays pending until fully sent
        if (wakeDone) begin
            wakePend_next = 1'b0;
        end
        if (wakeReq) begin
            wakePend_next = 1'b1;
        end

        // sticky status, write one to clear, set wins
        if (stWrite && regWrData[STAT_FAIL_BIT]) begin
            fail_next = 1'b0;
        end
        if (stWrite && regWrData[STAT_WEVT_BIT]) begin
            wakeEvt_next = 1'b0;
        end
        if (state_next == ST_FAILED) begin
            fail_next = 1'b1;
        end
        if (anyWake) begin
            wakeEvt_next = 1'b1;
        end
    end

    // --------
    // timers and transmit control
    // --------
    always_comb begin
        // state timer restarts on every state change
        if (state_next != state_reg) begin
            tmr_next = '0;
        end else if (tmr_reg != '1) begin
            tmr_next = tmr_reg + TMR_W'(1);
        end else begin
            tmr_next = tmr_reg;
        end

        // sleep command length counter, saturates at 64 bit times
        if (!txCtl_reg.txLps) begin
            lpsCnt_next = '0;
        end else if (lpsCnt_reg != LPS_DONE) begin
            lpsCnt_next = lpsCnt_reg + CNT_W'(1);
        end else begin
            lpsCnt_next = lpsCnt_reg;
        end

        // wake command or pulse length; a break restarts it
        if ((txCtl_reg.txWur || txCtl_reg.txPulse) && !wakeDone) begin
            wakeCnt_next = wakeCnt_reg + TMR_W'(1);
        end else begin
            wakeCnt_next = '0;
        end

        // energy filter: input must stay high for the filter time
        if (!nrgSyncB_reg || !txCtl_reg.energyDetEn) begin
            nrgCnt_next = '0;
        end else if (nrgCnt_reg != NRG_FULL) begin
            nrgCnt_next = nrgCnt_reg + CNT_W'(1);
        end else begin
            nrgCnt_next = nrgCnt_reg;
        end

        // transmit controls follow the next state
        txCtl_next             = '0;
        txCtl_next.txLps       = state_next == ST_HSREQ;
        txCtl_next.txSilent    = state_next == ST_QUIET;
        txCtl_next.txPowerDown = state_next == ST_SLEEP;
        // detection off in quiet to avoid mutual wake on our own tail
        txCtl_next.energyDetEn = state_next != ST_QUIET;
        if (state_next == ST_NORMAL && wakePend_next) begin
            if (txMode == MODE_NORMAL && rcvrOk) begin
                // commands only ride on idle; training waits
                txCtl_next.txWur = idleSlot;
            end else if (txMode == MODE_SILENT) begin
                txCtl_next.txPulse = 1'b1;
            end
        end

        // indications: one-cycle pulses
        wInd_next  = linkDown && anyWake;
        sFail_next = state_next == ST_FAILED && state_reg != ST_FAILED;
        // forwarding leaves the cycle after detection
        fwd_next   = ctrl_reg[CTRL_FWD_BIT] && (wurRcvd || energyHit);
    end

    // --------
    // registers
    // --------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg    <= ST_NORMAL;
            tmr_reg      <= '0;
            lpsCnt_reg   <= '0;
            wakeCnt_reg  <= '0;
            nrgCnt_reg   <= '0;
            restPend_reg <= 1'b0;
            lpsSeen_reg  <= 1'b0;
            reject_reg   <= 1'b0;
            wakePend_reg <= 1'b0;
            wakeHold_reg <= 1'b0;
            fail_reg     <= 1'b0;
            wakeEvt_reg  <= 1'b0;
            txCtl_reg    <= TXCTL_RST;
            wInd_reg     <= 1'b0;
            sFail_reg    <= 1'b0;
            fwd_reg      <= 1'b0;
            nrgSyncA_reg <= 1'b0;
            nrgSyncB_reg <= 1'b0;
            fwdSyncA_reg <= 1'b0;
            fwdSyncB_reg <= 1'b0;
            fwdSyncC_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            tmr_reg      <= tmr_next;
            lpsCnt_reg   <= lpsCnt_next;
            wakeCnt_reg  <= wakeCnt_next;
            nrgCnt_reg   <= nrgCnt_next;
            restPend_reg <= restPend_next;
            lpsSeen_reg  <= lpsSeen_next;
            reject_reg   <= reject_next;
            wakePend_reg <= wakePend_next;
            wakeHold_reg <= wakeHold_next;
            fail_reg     <= fail_next;
            wakeEvt_reg  <= wakeEvt_next;
            txCtl_reg    <= txCtl_next;
            wInd_reg     <= wInd_next;
            sFail_reg    <= sFail_next;
            fwd_reg      <= fwd_next;
            // pins pass two flops before anything looks at them
            nrgSyncA_reg <= lineEnergyPin;
            nrgSyncB_reg <= nrgSyncA_reg;
            fwdSyncA_reg <= wakeFwdInPin;
            fwdSyncB_reg <= fwdSyncA_reg;
            fwdSyncC_reg <= fwdSyncB_reg;
        end
    end

    // --------
    // outputs, all straight from flops
    // --------
    assign regRdData    = rdData_reg;
    assign txCtl        = txCtl_reg;
    assign seqState     = state_reg;
    assign wakeIndicate = wInd_reg;
    assign sleepFailInd = sFail_reg;
    assign wakeFwdOut   = fwd_reg;

endmodule // pssq_sequencer

// ==== pssq_sequencer_asserts.sv ====
`timescale 1ns/1ps
module pssq_sequencer_asserts
    import pssq_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // watched ports
    input wire pssq_state_t seqState,
    input wire pssq_txctl_t txCtl,
    input wire logic        lineActive,
    input wire logic        sleepFailInd
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // --------
    // sleep command run length
    // --------
    // saturates so a long handshake never wraps back to a short count
    logic [CNT_W-1:0] lpsRun_reg;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !txCtl.txLps)
            lpsRun_reg <= '0;
        else if (lpsRun_reg != '1)
            lpsRun_reg <= lpsRun_reg + 1'b1;
    end

    // --------
    // state machine checks
    // --------
    state_onehot_a: assert property ($onehot(seqState))
        else $error("state not one-hot");
    hsreq_lps_a: assert property (
        seqState == ST_HSREQ |-> txCtl.txLps)
        else $error("handshake state without sleep command");
    quiet_entry_a: assert property (
        $rose(seqState == ST_QUIET) |-> $past(seqState) == ST_HSREQ
        && $past(lpsRun_reg) >= CMD_CYCLES - 1)
        else $error("quiet entered without full sleep command");
    quiet_silent_a: assert property (seqState == ST_QUIET |->
        txCtl.txSilent && !txCtl.energyDetEn)
        else $error("quiet state not silent or detector on");
    sleep_entry_a: assert property ($rose(seqState == ST_SLEEP) |->
        $past(seqState) == ST_QUIET && !$past(lineActive))
        else $error("sleep entered with line active");
    sleep_txoff_a: assert property (
        seqState == ST_SLEEP |-> txCtl.txPowerDown)
        else $error("transmitter powered in sleep");
    fail_return_a: assert property (seqState == ST_FAILED |=>
        seqState == ST_NORMAL)
        else $error("failed state did not return to normal");
    fail_cause_a: assert property (
        $rose(seqState == ST_FAILED) |->
        $past(seqState) == ST_HSREQ ##[0:2] sleepFailInd)
        else $error("failure without handshake or indication");
    fail_pulse_a: assert property (sleepFailInd |=> !sleepFailInd)
        else $error("failure indication longer than a cycle");
    ack_exit_a: assert property ($fell(seqState == ST_ACKWT) |->
        seqState inside {ST_NORMAL, ST_HSREQ})
        else $error("acknowledge wait left to a wrong state");

    sleep_seen_c: cover property ($rose(seqState == ST_SLEEP));
    fail_seen_c: cover property ($rose(seqState == ST_FAILED));
    reject_seen_c: cover property ($fell(seqState == ST_ACKWT) &&
        seqState == ST_NORMAL);
endmodule // pssq_sequencer_asserts

bind pssq_sequencer pssq_sequencer_asserts i_pssq_sequencer_asserts (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .seqState(seqState),
    .txCtl(txCtl), .lineActive(lineActive), .sleepFailInd(sleepFailInd));

// ==== pssq_partner.sv ====
`timescale 1ns/1ps
module pssq_partner
    import pssq_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // device transmitter and bench control
    input  wire pssq_txctl_t txCtl,
    input  wire logic        agree,
    input  wire logic        initiate,
    // receive status toward the device
    output      logic        lpsRcvd,
    output      logic        lineActive
);
    logic [CNT_W-1:0] heard_reg;
    logic [CNT_W-1:0] sent_reg;
    logic [3:0]       linger_reg;
    logic             sending;

    // a heard sleep command is answered only when told to agree
    assign sending = initiate || (agree && heard_reg >= CMD_CYCLES);
    // saturating counters: heard, own command length, quiet linger
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            heard_reg <= '0;
            sent_reg <= '0;
            linger_reg <= '0;
        end else begin
            heard_reg <= txCtl.txLps ? heard_reg + (heard_reg != '1) : '0;
            sent_reg <= sending ? sent_reg + (sent_reg != '1) : '0;
            linger_reg <= txCtl.txSilent ? linger_reg + (linger_reg != '1)
                                         : '0;
        end
    end
    // a command counts only once fully sent
    assign lpsRcvd = sent_reg >= CMD_CYCLES;
    // partner keeps talking a while after the device falls silent
    assign lineActive = !txCtl.txPowerDown &&
                        (!txCtl.txSilent || linger_reg != '1);
endmodule // pssq_partner

// ==== pssq_sequencer_test.sv ====
`timescale 1ns/1ps
module pssq_sequencer_test import pssq_pkg::*;;
    localparam logic [TMR_W-1:0] ACK = 20'h32, HS = 20'h78, PLS = 20'h1e;
    logic sys_clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0, regRdData;
    pssq_txmode_t txMode = MODE_NORMAL;
    logic rcvrOk = 1'b1, wurRcvd = 1'b0, idleSlot = 1'b1, agree = 1'b0;
    logic lineEnergyPin = 1'b0, wakeFwdInPin = 1'b0, initiate = 1'b0;
    logic lpsRcvd, lineActive, wakeIndicate, sleepFailInd, wakeFwdOut;
    pssq_txctl_t txCtl;
    pssq_state_t seqState;
    int miscompares = 0, compares = 0, cyc = 0;

    pssq_sequencer #(.ACK_WIN_CYC(ACK), .HS_TO_CYC(HS), .PULSE_CYC(PLS))
    i_pssq_sequencer (.sys_clk, .sys_rst, .regAddr, .regWrData, .regWr,
        .regRd, .regRdData, .txMode, .rcvrOk, .lpsRcvd, .wurRcvd,
        .lineActive, .idleSlot, .lineEnergyPin, .wakeFwdInPin, .txCtl,
        .seqState, .wakeIndicate, .sleepFailInd, .wakeFwdOut);
    pssq_partner i_pssq_partner (.sys_clk, .sys_rst, .txCtl, .agree,
        .initiate, .lpsRcvd, .lineActive);

    // --------
    // clock, hang guard and shared tasks
    // --------
    initial forever #12.5 sys_clk = ~sys_clk;
    // whole run is well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out;
        $display("counts: %0d compares, %0d miscompares", compares,
                 miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (exp !== got) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic wait_st(pssq_state_t s, int n, output int used);
        #1 used = 0;
        while (seqState !== s && used < n) begin
            @(posedge sys_clk);
            #1 used++;
        end
        check("state", s, seqState);
    endtask
    // counts pulse and wake command cycles, catches forward and indicate
    task automatic watch(int c, output int pl, wu, output logic fw, wi);
        {pl, wu, fw, wi} = '0;
        repeat (c) begin
            #1 pl += txCtl.txPulse;
            wu += txCtl.txWur;
            fw |= wakeFwdOut;
            wi |= wakeIndicate;
            @(posedge sys_clk);
        end
        #1;
    endtask

    // --------
    // scenarios
    // --------
    task automatic t_sleep;
        int n, pl, wu;
        logic fw, wi;
        logic [31:0] d;
        check("txCtl", TXCTL_RST, txCtl);
        check("state", ST_NORMAL, seqState);
        rd(REG_CTRL, d);
        check("ctrl", 0, d);
        rd(8'hfc, d);
        check("unmapped", 0, d);
        agree <= 1'b1;
        wr(REG_CTRL, 32'h3);
        wr(REG_CMD, 32'h1);
        wait_st(ST_HSREQ, 4, n);
        wait_st(ST_QUIET, 80, n);
        check("quiet", 2'h2, {txCtl.txSilent, txCtl.energyDetEn});
        wait_st(ST_SLEEP, 30, n);
        check("powerdown", 1, txCtl.txPowerDown);
        agree <= 1'b0;
        txMode <= MODE_SILENT;
        wr(REG_CMD, 32'h2);
        watch(60, pl, wu, fw, wi);
        check("pulse", PLS, pl);
        check("indicate", 1, wi);
        wait_st(ST_NORMAL, 2, n);
        txMode <= MODE_NORMAL;
        $display("test sleep done");
    endtask
    task automatic t_ack;
        int n;
        initiate <= 1'b1;
        wait_st(ST_ACKWT, 40, n);
        initiate <= 1'b0;
        wr(REG_CMD, 32'h4);
        wait_st(ST_NORMAL, 3, n);
        repeat (10) @(posedge sys_clk);
        #1 check("stay", ST_NORMAL, seqState);
        initiate <= 1'b1;
        wait_st(ST_ACKWT, 40, n);
        wait_st(ST_HSREQ, 60, n);
        check("window", 1, n >= ACK - 3 && n <= ACK + 2);
        wait_st(ST_QUIET, 40, n);
        initiate <= 1'b0;
        wr(REG_CMD, 32'h2);
        wait_st(ST_SLEEP, 20, n);
        wait_st(ST_NORMAL, 2, n);
        repeat (40) @(posedge sys_clk);
        $display("test acknowledge done");
    endtask
    task automatic t_fail;
        int n;
        logic [31:0] d;
        wr(REG_CMD, 32'h1);
        wait_st(ST_HSREQ, 4, n);
        wr(REG_CMD, 32'h2);
        wait_st(ST_NORMAL, 3, n);
        repeat (40) @(posedge sys_clk);
        wr(REG_CMD, 32'h1);
        wait_st(ST_HSREQ, 4, n);
        wait_st(ST_FAILED, 130, n);
        check("fail ind", 1, sleepFailInd);
        check("timeout", 1, n >= HS - 3 && n <= HS + 2);
        wait_st(ST_NORMAL, 2, n);
        rd(REG_STATUS, d);
        check("fail flag", 1, d[STAT_FAIL_BIT]);
        $display("test fail done");
    endtask
    task automatic t_wake;
        int pl, wu;
        logic fw, wi;
        txMode <= MODE_TRAINING;
        rcvrOk <= 1'b0;
        wr(REG_CMD, 32'h2);
        watch(20, pl, wu, fw, wi);
        check("held", 0, pl + wu);
        txMode <= MODE_NORMAL;
        rcvrOk <= 1'b1;
        watch(60, pl, wu, fw, wi);
        check("wur", 1, wu >= CMD_CYCLES);
        txMode <= MODE_SILENT;
        wurRcvd <= 1'b1;
        @(posedge sys_clk) wurRcvd <= 1'b0;
        watch(50, pl, wu, fw, wi);
        check("fwd wur", 1, fw);
        lineEnergyPin <= 1'b1;
        watch(80, pl, wu, fw, wi);
        lineEnergyPin <= 1'b0;
        check("fwd energy", 1, fw);
        check("energy ind", 1, wi);
        wakeFwdInPin <= 1'b1;
        watch(40, pl, wu, fw, wi);
        wakeFwdInPin <= 1'b0;
        check("fwd in", PLS, pl);
        $display("test wake done");
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        #1 t_sleep();
        t_ack();
        t_fail();
        t_wake();
        close_out();
    end
endmodule // pssq_sequencer_test
